// >>> hw/lfch_config_header.sv
// link function configuration header: window bases, subsystem identity,
// capability pointer and interrupt routing, reached by configuration
// reads and writes.
// assumes requests come from a configuration decoder on clk_sys, one
// request at a time, and that the loader sits on the same clock.
//
// Operation
// - link window base bits 31..11 are writable, holding the upper 21 bits.
// - writing all ones to link window base reads back FFFF F800h.
// - link window base bits 10..4 read zero, meaning a 2-Kbyte window.
// - link window base bit 3 reads zero: not prefetchable.
// - link window base bits 2..1 read zero: 32-bit base anywhere.
// - link window base bit 0 reads zero: memory space.
// - extension window base at 14h, bits 31..11 hold its pointer.
// - extension window base bits 10..4 read zero: 2-Kbyte window.
// - extension window base bit 3 reads zero: not prefetchable.
// - extension window base bits 2..1 read zero: 32-bit base anywhere.
// - extension window base bit 0 reads zero: memory space.
// - subsystem register at 2Ch: device code high half, vendor code low.
// - subsystem identity loads from serial EEPROM or access register only.
// - capability pointer at 34h reads fixed 44h, writes ignored.
// - power-management block lives in dwords 44h and 48h.
// - interrupt register: upper byte read-only, lower byte read/write.
// - interrupt pin field reads 01h, 02h or 03h.
`include "lfch_defs.svh"
`default_nettype none

module lfch_config_header #(
	parameter logic [7:0] INTERRUPT_PIN_CODE = `LFCH_IRQ_PIN_DEFAULT
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire lfch_pkg::lfch_cfg_req_type  cfg_req,
	output lfch_pkg::lfch_cfg_rsp_type       cfg_rsp,
	input  wire lfch_pkg::lfch_ssid_upd_type eeprom_upd,
	input  wire lfch_pkg::lfch_ssid_upd_type access_upd,
	output logic [20:0]                      link_window_pointer,
	output logic [20:0]                      extension_window_pointer,
	output logic [31:0]                      subsystem_identity,
	output logic [7:0]                       interrupt_routing_line,
	output logic                             pm_block_access
);

	// ****************************************************************
	// address decode
	// ****************************************************************

	// dword index of the request; byte lane bits are not decoded
	logic [5:0] req_dword;
	logic       hit_link;
	logic       hit_ext;
	logic       hit_subsys;
	logic       hit_cap;
	logic       hit_intr;
	logic       hit_pm;
	logic       req_any;

	localparam logic [5:0] DW_LINK   = 6'(`LFCH_OFS_LINK_BASE >> 2);
	localparam logic [5:0] DW_EXT    = 6'(`LFCH_OFS_EXT_BASE >> 2);
	localparam logic [5:0] DW_SUBSYS = 6'(`LFCH_OFS_SUBSYS >> 2);
	localparam logic [5:0] DW_CAP    = 6'(`LFCH_OFS_CAP_PTR >> 2);
	localparam logic [5:0] DW_INTR   = 6'(`LFCH_OFS_INTR >> 2);
	localparam logic [5:0] DW_PM_A   = 6'(`LFCH_OFS_PM_FIRST >> 2);
	localparam logic [5:0] DW_PM_B   = 6'(`LFCH_OFS_PM_SECOND >> 2);

	assign req_dword  = cfg_req.addr[7:2];
	assign req_any    = cfg_req.rd | cfg_req.wr;
	assign hit_link   = (req_dword == DW_LINK);
	assign hit_ext    = (req_dword == DW_EXT);
	assign hit_subsys = (req_dword == DW_SUBSYS);
	assign hit_cap    = (req_dword == DW_CAP);
	assign hit_intr   = (req_dword == DW_INTR);
	// the power-management dwords belong to logic outside this block
	assign hit_pm     = (req_dword == DW_PM_A) ||
	                    (req_dword == DW_PM_B);

	// ****************************************************************
	// window base registers
	// ****************************************************************

	logic [31:0] link_word;
	logic [31:0] ext_word;
	logic [20:0] link_ptr;
	logic [20:0] ext_ptr;
	logic        link_wr;
	logic        ext_wr;

	// a read takes precedence if a decoder ever raises both strobes
	assign link_wr = cfg_req.wr & ~cfg_req.rd & hit_link;
	assign ext_wr  = cfg_req.wr & ~cfg_req.rd & hit_ext;

	// link window: only bits 31..11 store, low bits read zero
	lfch_window_base u_link_base (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.wr_en     (link_wr),
		.be        (cfg_req.be),
		.wdata     (cfg_req.wdata),
		.pointer   (link_ptr),
		.read_word (link_word)
	);

	// extension window: same 2-Kbyte memory layout
	lfch_window_base u_ext_base (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.wr_en     (ext_wr),
		.be        (cfg_req.be),
		.wdata     (cfg_req.wdata),
		.pointer   (ext_ptr),
		.read_word (ext_word)
	);

	// ****************************************************************
	// subsystem identity
	// ****************************************************************

	logic [31:0] ssid_word;

	// no configuration write path reaches it; a write at 2Ch is dropped
	lfch_subsys_id u_subsys (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.eeprom_upd (eeprom_upd),
		.access_upd (access_upd),
		.identity   (ssid_word)
	);

	// ****************************************************************
	// top state
	// ****************************************************************

	lfch_pkg::lfch_main_state_type state_reg;
	lfch_pkg::lfch_main_state_type state_next;

	// read word of the addressed dword; unmapped dwords read zero
	logic [31:0] read_word;

	always_comb begin
		read_word = `LFCH_RDATA_RESET;
		if (hit_link) begin
			read_word = link_word;
		end else if (hit_ext) begin
			read_word = ext_word;
		end else if (hit_subsys) begin
			read_word = ssid_word;
		end else if (hit_cap) begin
			// pointer sits in the low byte; the rest of the dword is zero
			read_word = {24'h000000, `LFCH_CAP_PTR_VALUE};
		end else if (hit_intr) begin
			// pin code high, line low; the upper half is not ours
			read_word = {16'h0000, INTERRUPT_PIN_CODE,
			             state_reg.routing_line};
		end
	end

	// one answer per request, registered on the edge that takes it
	always_comb begin
		state_next        = state_reg;
		state_next.ack    = req_any;
		state_next.pm_hit = req_any & hit_pm;
		// read data hold until the next read so a slow master keeps them
		if (cfg_req.rd) begin
			state_next.rdata = read_word;
		end
		// only the line byte takes data; the pin byte stays fixed
		if (cfg_req.wr && !cfg_req.rd && hit_intr && cfg_req.be[0]) begin
			state_next.routing_line = cfg_req.wdata[7:0];
		end
	end

	// register the state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg.ack          <= 1'b0;
			state_reg.rdata        <= `LFCH_RDATA_RESET;
			state_reg.routing_line <= `LFCH_IRQ_LINE_RESET;
			state_reg.pm_hit       <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	// every output below is a flip-flop, here or in a child module
	// one driver for the whole answer struct
	assign cfg_rsp = '{ack: state_reg.ack, rdata: state_reg.rdata};
	assign link_window_pointer       = link_ptr;
	assign extension_window_pointer  = ext_ptr;
	assign subsystem_identity        = ssid_word;
	assign interrupt_routing_line    = state_reg.routing_line;
	assign pm_block_access           = state_reg.pm_hit;

endmodule

`default_nettype wire

// >>> hw/lfch_defs.svh
// constants of the link function configuration header: offsets, field
// positions, fixed values and reset values.
// assumes inclusion by bare name from files under hw/.
`ifndef LFCH_DEFS_SVH
`define LFCH_DEFS_SVH

// ****************************************************************
// configuration offsets (byte addresses, dword aligned)
// ****************************************************************
`define LFCH_OFS_LINK_BASE      8'h10
`define LFCH_OFS_EXT_BASE       8'h14
`define LFCH_OFS_SUBSYS         8'h2C
`define LFCH_OFS_CAP_PTR        8'h34
`define LFCH_OFS_INTR           8'h3C
`define LFCH_OFS_PM_FIRST       8'h44
`define LFCH_OFS_PM_SECOND      8'h48

// ****************************************************************
// window base register layout
// ****************************************************************
`define LFCH_BASE_PTR_MSB       31
`define LFCH_BASE_PTR_LSB       11
`define LFCH_BASE_PTR_WIDTH     21
`define LFCH_BASE_LOW_ZERO      11'h000
`define LFCH_BASE_RESET         21'h00000

// ****************************************************************
// fixed and reset values
// ****************************************************************
`define LFCH_CAP_PTR_VALUE      8'h44
`define LFCH_IRQ_PIN_DEFAULT    8'h01
`define LFCH_IRQ_LINE_RESET     8'h00
`define LFCH_SUBSYS_RESET       32'h00000000
`define LFCH_RDATA_RESET        32'h00000000

`endif

// >>> hw/lfch_pkg.sv
// types shared by the link function configuration header files.
// assumes the constants header is compiled alongside.
`default_nettype none

package lfch_pkg;

	// configuration request as presented by the host side decoder
	typedef struct packed {
		logic [7:0]  addr;
		logic        rd;
		logic        wr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} lfch_cfg_req_type;

	// configuration answer, one cycle after the request
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} lfch_cfg_rsp_type;

	// subsystem identity update from loader or access register
	typedef struct packed {
		logic        load;
		logic [3:0]  be;
		logic [31:0] data;
	} lfch_ssid_upd_type;

	// state of the top module
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [7:0]  routing_line;
		logic        pm_hit;
	} lfch_main_state_type;

endpackage

`default_nettype wire

// >>> hw/lfch_window_base.sv
// one 32-bit memory window base register with a 2-Kbyte decode.
// assumes the caller raises wr_en only for a write aimed at this offset.
`include "lfch_defs.svh"
`default_nettype none

module lfch_window_base (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [3:0]  be,
	input  wire logic [31:0] wdata,
	output logic [20:0]      pointer,
	output logic [31:0]      read_word
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [20:0] pointer_reg;
	logic [20:0] pointer_next;
	logic [31:0] merged;
	logic [31:0] current;

	assign current = {pointer_reg, `LFCH_BASE_LOW_ZERO};

	// byte lanes pick new or old data per byte
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign merged[lane*8 +: 8] = be[lane] ?
				wdata[lane*8 +: 8] : current[lane*8 +: 8];
		end
	endgenerate

	// only bits 31..11 take data; low bits never store anything
	always_comb begin
		pointer_next = pointer_reg;
		if (wr_en) begin
			pointer_next = merged[`LFCH_BASE_PTR_MSB:`LFCH_BASE_PTR_LSB];
		end
	end

	// register the pointer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pointer_reg <= `LFCH_BASE_RESET;
		end else begin
			pointer_reg <= pointer_next;
		end
	end

	assign pointer = pointer_reg;
	// size, prefetch, type and space bits all read as zero
	assign read_word = current;

endmodule

`default_nettype wire

// >>> hw/lfch_subsys_id.sv
// subsystem identity holding register: device code high, vendor code low.
// assumes loader and access-register strobes come from the same clock.
`include "lfch_defs.svh"
`default_nettype none

module lfch_subsys_id (
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	input  wire lfch_pkg::lfch_ssid_upd_type eeprom_upd,
	input  wire lfch_pkg::lfch_ssid_upd_type access_upd,
	output logic [31:0]                   identity
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [31:0] ident_reg;
	logic [31:0] ident_next;
	logic [31:0] eeprom_word;
	logic [31:0] access_word;

	// per-lane merge for each update source
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign eeprom_word[lane*8 +: 8] = eeprom_upd.be[lane] ?
				eeprom_upd.data[lane*8 +: 8] : ident_reg[lane*8 +: 8];
			assign access_word[lane*8 +: 8] = access_upd.be[lane] ?
				access_upd.data[lane*8 +: 8] : ident_reg[lane*8 +: 8];
		end
	endgenerate

	// the loader wins a tie: it only runs after reset, before software
	always_comb begin
		ident_next = ident_reg;
		if (eeprom_upd.load) begin
			ident_next = eeprom_word;
		end else if (access_upd.load) begin
			ident_next = access_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ident_reg <= `LFCH_SUBSYS_RESET;
		end else begin
			ident_reg <= ident_next;
		end
	end

	assign identity = ident_reg;

endmodule

`default_nettype wire

// >>> tb/lfch_header_checker.sv
// concurrent checks on the configuration header top ports.
// assumes binding onto lfch_config_header, all on clk_sys.
`default_nettype none

// ****************************************************************
// header checker
// ****************************************************************
module lfch_header_checker #(
	parameter logic [7:0] INTERRUPT_PIN_CODE = 8'h01
) (
	input wire logic                        clk_sys,
	input wire logic                        rst_n,
	input wire lfch_pkg::lfch_cfg_req_type  cfg_req,
	input wire lfch_pkg::lfch_cfg_rsp_type  cfg_rsp,
	input wire lfch_pkg::lfch_ssid_upd_type eeprom_upd,
	input wire lfch_pkg::lfch_ssid_upd_type access_upd,
	input wire logic [20:0]                 link_window_pointer,
	input wire logic [20:0]                 extension_window_pointer,
	input wire logic [31:0]                 subsystem_identity,
	input wire logic [7:0]                  interrupt_routing_line,
	input wire logic                        pm_block_access
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// dword index; a read wins when both strobes are high
	logic [5:0]  dw;
	logic        rd;
	logic        wr;
	logic [31:0] rdat;
	assign dw = cfg_req.addr[7:2];
	assign rd = cfg_req.rd;
	assign wr = cfg_req.wr & ~cfg_req.rd;
	assign rdat = cfg_rsp.rdata;

	link_ptr_write_a: assert property (wr && dw == 6'h04 &&
		cfg_req.be == 4'hF |=> link_window_pointer ==
		$past(cfg_req.wdata[31:11])) else $error("link pointer write");
	link_read_back_a: assert property (rd && dw == 6'h04 |=>
		rdat[31:11] == $past(link_window_pointer))
		else $error("link base readback");
	link_low_zero_a: assert property (rd && dw == 6'h04 |=>
		cfg_rsp.ack && rdat[10:0] == 11'h000) else $error("link low bits");
	ext_ptr_write_a: assert property (wr && dw == 6'h05 &&
		cfg_req.be == 4'hF |=> extension_window_pointer ==
		$past(cfg_req.wdata[31:11])) else $error("ext pointer write");
	ext_low_zero_a: assert property (rd && dw == 6'h05 |=>
		cfg_rsp.ack && rdat[10:0] == 11'h000) else $error("ext low bits");
	subsys_read_a: assert property (rd && dw == 6'h0B |=>
		rdat == $past(subsystem_identity)) else $error("subsystem read");
	subsys_cfg_ignored_a: assert property (wr && dw == 6'h0B &&
		!eeprom_upd.load && !access_upd.load |=>
		$stable(subsystem_identity)) else $error("subsystem cfg write");
	cap_ptr_fixed_a: assert property (rd && dw == 6'h0D |=>
		rdat == 32'h00000044) else $error("capability pointer");
	pm_access_pulse_a: assert property ((rd || wr) &&
		(dw == 6'h11 || dw == 6'h12) |=> pm_block_access)
		else $error("pm block access");
	pm_access_quiet_a: assert property (!((rd || wr) &&
		(dw == 6'h11 || dw == 6'h12)) |=> !pm_block_access)
		else $error("pm block access without request");
	intr_read_a: assert property (rd && dw == 6'h0F |=>
		rdat == {16'h0000, INTERRUPT_PIN_CODE,
		$past(interrupt_routing_line)})
		else $error("interrupt register read");

	cover property (wr && dw == 6'h04 && cfg_req.be == 4'hF);
	cover property (wr && dw == 6'h0F);
	cover property (access_upd.load && eeprom_upd.load);
endmodule

bind lfch_config_header lfch_header_checker #(
	.INTERRUPT_PIN_CODE(INTERRUPT_PIN_CODE)
) chk_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req),
	.cfg_rsp(cfg_rsp), .eeprom_upd(eeprom_upd), .access_upd(access_upd),
	.link_window_pointer(link_window_pointer),
	.extension_window_pointer(extension_window_pointer),
	.subsystem_identity(subsystem_identity),
	.interrupt_routing_line(interrupt_routing_line),
	.pm_block_access(pm_block_access)
);

`default_nettype wire

// >>> tb/lfch_host_model.sv
// host configuration software model: issues configuration cycles.
// assumes the answer shows just after the clk_sys edge that takes the request.
`default_nettype none

// ****************************************************************
// host model
// ****************************************************************
module lfch_host_model (
	output lfch_pkg::lfch_cfg_req_type      cfg_req,
	input  wire logic                       clk_sys,
	input  wire lfch_pkg::lfch_cfg_rsp_type cfg_rsp
);
	timeunit 1ns;
	timeprecision 100ps;
	initial cfg_req = '0;

	// one-cycle request; lines are then scrambled, not held, so the
	// design cannot lean on stale address or data
	task automatic access(input logic [7:0] a, input logic r,
		input logic [3:0] be, input logic [31:0] d,
		output logic [32:0] ans);
		@(posedge clk_sys);
		#1;
		cfg_req = '{addr: a, rd: r, wr: ~r, be: be, wdata: d};
		@(posedge clk_sys);
		#1;
		cfg_req = '{addr: ~a, rd: 1'b0, wr: 1'b0, be: ~be, wdata: ~d};
		ans = {cfg_rsp.ack, cfg_rsp.rdata};
	endtask
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the link function configuration header.
// assumes the host model drives the configuration request port.
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
	fail_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

// ****************************************************************
// bench top
// ****************************************************************
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] PIN = 8'h02;
	logic                        clk_sys;
	logic                        rst_n;
	lfch_pkg::lfch_cfg_req_type  cfg_req;
	lfch_pkg::lfch_cfg_rsp_type  cfg_rsp;
	lfch_pkg::lfch_ssid_upd_type eeprom_upd;
	lfch_pkg::lfch_ssid_upd_type access_upd;
	logic [20:0]                 link_ptr;
	logic [20:0]                 ext_ptr;
	logic [31:0]                 ident;
	logic [7:0]                  line_byte;
	logic                        pm_hit;
	logic [32:0]                 ans;
	int                          fail_count;
	int                          check_count;

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	lfch_host_model host_u (.clk_sys(clk_sys), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp));
	lfch_config_header #(.INTERRUPT_PIN_CODE(PIN)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req),
		.cfg_rsp(cfg_rsp), .eeprom_upd(eeprom_upd),
		.access_upd(access_upd), .link_window_pointer(link_ptr),
		.extension_window_pointer(ext_ptr), .subsystem_identity(ident),
		.interrupt_routing_line(line_byte), .pm_block_access(pm_hit));

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		host_u.access(a, 1'b0, be, d, ans);
		`CHK("write ack", 1'b1, ans[32])
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		host_u.access(a, 1'b1, 4'h0, 32'h0, ans);
		`CHK("read", {1'b1, ex}, ans)
	endtask

	// loader and access-register strobes, one cycle each
	task automatic upd(input logic e, input logic a, input logic [3:0] be,
		input logic [31:0] de, input logic [31:0] da);
		@(posedge clk_sys);
		#1;
		eeprom_upd = '{load: e, be: be, data: de};
		access_upd = '{load: a, be: be, data: da};
		@(posedge clk_sys);
		#1;
		eeprom_upd.load = 1'b0;
		access_upd.load = 1'b0;
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		fail_count = 0;
		check_count = 0;
		eeprom_upd = '0;
		access_upd = '0;
		repeat (16) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		`CHK("link ptr", 21'h00000, link_ptr)
		rd(8'h10, 32'h00000000);
		rd(8'h14, 32'h00000000);
		rd(8'h2C, 32'h00000000);
		rd(8'h3C, {16'h0000, PIN, 8'h00});
		wr(8'h10, 4'hF, 32'hFFFFFFFF);
		rd(8'h10, 32'hFFFFF800);
		`CHK("link ptr", 21'h1FFFFF, link_ptr)
		wr(8'h14, 4'hF, 32'hFFFFFFFF);
		rd(8'h14, 32'hFFFFF800);
		`CHK("ext ptr", 21'h1FFFFF, ext_ptr)
		wr(8'h13, 4'hF, 32'hA5A5A5A5);
		rd(8'h10, 32'hA5A5A000);
		wr(8'h10, 4'h2, 32'h0000FFFF);
		rd(8'h10, 32'hA5A5F800);
		wr(8'h34, 4'hF, 32'h00000000);
		rd(8'h34, 32'h00000044);
		wr(8'h3C, 4'hF, 32'hFFFFFFFF);
		rd(8'h3C, {16'h0000, PIN, 8'hFF});
		`CHK("routing line", 8'hFF, line_byte)
		wr(8'h2C, 4'hF, 32'hFFFFFFFF);
		rd(8'h2C, 32'h00000000);
		upd(1'b0, 1'b1, 4'hF, 32'h0, 32'h12345678);
		rd(8'h2C, 32'h12345678);
		upd(1'b1, 1'b1, 4'h3, 32'h0000BEEF, 32'h0000CAFE);
		`CHK("identity", 32'h1234BEEF, ident)
		rd(8'h44, 32'h00000000);
		`CHK("pm access", 1'b1, pm_hit)
		rd(8'h48, 32'h00000000);
		`CHK("pm access", 1'b1, pm_hit)
		rd(8'h20, 32'h00000000);
		`CHK("pm access", 1'b0, pm_hit)
		stop_test();
	end
endmodule

`default_nettype wire
